// ==== dv/bprs_monitor.sv ====
// Port checker for the reset sequencer.
// Assumes it is bound to bprs_sequencer; config is tracked from writes.
module bprs_monitor (
    input wire logic MCLK_I,
    input wire logic RST_B_I,
    input wire logic SUPPLY_LOW_I,
    input wire logic MASTER_CLEAR_PIN_B_I,
    input wire logic FETCH_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic CORE_RST_B_O,
    input wire logic PARITY_ERR_O
);
    logic [7:0] cfg;
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I)
            cfg <= bprs_pkg::CFG_RESET;
        else if (WR_I && ADDR_I == bprs_pkg::ADDR_CFG)
            cfg <= WDATA_I;
    end
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_B_I);
    chk_par_resets: assert property (
        PARITY_ERR_O |-> !CORE_RST_B_O) else $error("parity without reset");
    chk_par_cause: assert property (
        PARITY_ERR_O |-> $past(FETCH_I)) else $error("parity without fetch");
    chk_par_off: assert property (
        FETCH_I && !cfg[2] |=> !PARITY_ERR_O) else $error("parity when off");
    chk_master_clear_pin_hold: assert property (
        !MASTER_CLEAR_PIN_B_I |=> !CORE_RST_B_O) else $error("clear ignored");
    chk_rel_master_clear_pin: assert property (
        $rose(CORE_RST_B_O) |-> $past(MASTER_CLEAR_PIN_B_I))
        else $error("release with clear low");
    chk_pwrup_hold: assert property (
        $rose(RST_B_I) |-> !CORE_RST_B_O [*8]) else $error("early release");
    chk_bor_hold: assert property (
        cfg[0] && SUPPLY_LOW_I |-> ##[1:2] !CORE_RST_B_O)
        else $error("brown-out missed");
    chk_mpe_read: assert property (
        RD_I && ADDR_I == bprs_pkg::ADDR_PWR_STATUS |=>
        RDATA_O[7] == $past(cfg[2]) && RDATA_O[6:3] == 4'h0)
        else $error("status bit 7 wrong");
    cover property (PARITY_ERR_O);
    cover property ($rose(CORE_RST_B_O));
    cover property (cfg[0] && SUPPLY_LOW_I);
endmodule
bind bprs_sequencer bprs_monitor u_bprs_monitor (.MCLK_I, .RST_B_I,
    .SUPPLY_LOW_I, .MASTER_CLEAR_PIN_B_I, .FETCH_I, .ADDR_I, .WDATA_I,
    .WR_I, .RD_I, .RDATA_O, .CORE_RST_B_O, .PARITY_ERR_O);

// ==== dv/bprs_pmem_model.sv ====
// Program memory model: gives the stored parity bits of a fetched word.
// Assumes 14-bit words; bad_* requests corrupt one stored bit on purpose.
module bprs_pmem_model (
    // Fetched word
    input wire logic [13:0] word_i,
    // Corruption requests
    input wire logic bad_even_i,
    input wire logic bad_odd_i,
    // Stored parity bits
    output logic par_even_o,
    output logic par_odd_o
);
    logic [6:0] ev;
    logic [6:0] od;
    always_comb begin
        for (int k = 0; k < 7; k++) begin
            ev[k] = word_i[2*k];
            od[k] = word_i[2*k+1];
        end
    end
    assign par_even_o = (^ev) ^ bad_even_i;
    assign par_odd_o = ~(^od) ^ bad_odd_i;
endmodule

// ==== dv/bprs_sequencer_tb_top.sv ====
// Self-checking bench for the reset sequencer.
// Assumes delays shortened to 50 and 8 cycles and a 10 MHz clock.
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
    n_errors++; $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); \
    end end
module bprs_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PW = 50;
    localparam int OS = 8;
    typedef struct {logic [13:0] w; logic be; logic bo; logic e;} bprs_row_s;
    logic MCLK_I = 1'h0, RST_B_I = 1'h0, SUPPLY_LOW_I = 1'h0, WR_I = 1'h0;
    logic MASTER_CLEAR_PIN_B_I = 1'h1, WDT_TIMEOUT_I = 1'h0, SLEEP_I = 1'h0;
    logic WAKE_WDT_I = 1'h0, WAKE_INT_I = 1'h0, FETCH_I = 1'h0, RD_I = 1'h0;
    logic FETCH_PAR_EVEN_I, FETCH_PAR_ODD_I, bad_e = 1'h0, bad_o = 1'h0;
    logic CORE_RST_B_O, WAKE_HOLD_O, PARITY_ERR_O;
    logic [13:0] FETCH_WORD_I = 14'h0000;
    logic [3:0] ADDR_I = 4'h0;
    logic [7:0] WDATA_I = 8'h00, RDATA_O, d;
    int n_errors = 0, cmp_count = 0, n;
    bprs_row_s rows[5] = '{'{14'h0000, 1'h0, 1'h0, 1'h0},
        '{14'h2AAA, 1'h0, 1'h0, 1'h0}, '{14'h1555, 1'h1, 1'h0, 1'h1},
        '{14'h3FFF, 1'h0, 1'h1, 1'h1}, '{14'h0F0F, 1'h1, 1'h1, 1'h1}};
    bprs_sequencer #(.PWRUP_CYC(PW), .OST_CYC(OS)) u_bprs_sequencer (
        .MCLK_I, .RST_B_I, .SUPPLY_LOW_I, .MASTER_CLEAR_PIN_B_I,
        .WDT_TIMEOUT_I, .SLEEP_I, .WAKE_WDT_I, .WAKE_INT_I, .FETCH_I,
        .FETCH_WORD_I, .FETCH_PAR_EVEN_I, .FETCH_PAR_ODD_I, .ADDR_I,
        .WDATA_I, .WR_I, .RD_I, .RDATA_O, .CORE_RST_B_O, .WAKE_HOLD_O,
        .PARITY_ERR_O);
    bprs_pmem_model u_bprs_pmem_model (.word_i(FETCH_WORD_I),
        .bad_even_i(bad_e), .bad_odd_i(bad_o),
        .par_even_o(FETCH_PAR_EVEN_I), .par_odd_o(FETCH_PAR_ODD_I));
    always #50 MCLK_I = ~MCLK_I;
    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge MCLK_I);
        ADDR_I <= a;
        WDATA_I <= v;
        WR_I <= 1'h1;
        @(posedge MCLK_I);
        WR_I <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge MCLK_I);
        ADDR_I <= a;
        RD_I <= 1'h1;
        @(posedge MCLK_I);
        RD_I <= 1'h0;
        #1 v = RDATA_O;
    endtask
    // Counts cycles until the core leaves reset; gives up after 300
    task automatic wait_run(output int c);
        c = 0;
        while (CORE_RST_B_O !== 1'h1 && c < 300) begin
            @(posedge MCLK_I);
            #1 c++;
        end
        if (c >= 300) begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    task automatic dip(input int k);
        @(posedge MCLK_I);
        SUPPLY_LOW_I <= 1'h1;
        repeat (k) @(posedge MCLK_I);
        SUPPLY_LOW_I <= 1'h0;
        repeat (2) @(posedge MCLK_I);
    endtask
    initial begin
        repeat (10) @(posedge MCLK_I);
        RST_B_I <= 1'h1;
        wait_run(n);
        `CHK(n >= PW + OS, 1'h1)
        rd(4'h0, d);
        `CHK(d, 8'h84)
        rd(4'h1, d);
        `CHK(d, 8'h03)
        rd(4'h2, d);
        `CHK(d, 8'h0D)
        rd(4'hF, d);
        `CHK(d, 8'h00)
        wr(4'h0, 8'h07);
        rd(4'h0, d);
        `CHK(d, 8'h87)
        foreach (rows[i]) begin
            @(posedge MCLK_I);
            FETCH_WORD_I <= rows[i].w;
            bad_e <= rows[i].be;
            bad_o <= rows[i].bo;
            FETCH_I <= 1'h1;
            @(posedge MCLK_I);
            FETCH_I <= 1'h0;
            #1 `CHK(PARITY_ERR_O, rows[i].e)
            wait_run(n);
            rd(4'h0, d);
            `CHK(d, rows[i].e ? 8'h83 : 8'h87)
            wr(4'h0, 8'h07);
            $display("parity row %0d done", i);
        end
        dip(20);
        #1 `CHK(CORE_RST_B_O, 1'h0)
        repeat (28) @(posedge MCLK_I);
        dip(1);
        wait_run(n);
        `CHK(n >= PW, 1'h1)
        rd(4'h0, d);
        `CHK(d, 8'h86)
        $display("brown-out test done");
        wr(4'h2, 8'h0C);
        dip(5);
        #1 `CHK(CORE_RST_B_O, 1'h1)
        wr(4'h2, 8'h1D);
        dip(1);
        #1 `CHK(CORE_RST_B_O, 1'h0)
        wait_run(n);
        `CHK(n > PW - 4 && n < PW + OS - 4, 1'h1)
        wr(4'h2, 8'h1E);
        @(posedge MCLK_I);
        bad_e <= 1'h1;
        FETCH_I <= 1'h1;
        @(posedge MCLK_I);
        FETCH_I <= 1'h0;
        #1 `CHK(PARITY_ERR_O, 1'h1)
        wait_run(n);
        `CHK(n <= 3, 1'h1)
        @(posedge MCLK_I);
        WDT_TIMEOUT_I <= 1'h1;
        @(posedge MCLK_I);
        WDT_TIMEOUT_I <= 1'h0;
        repeat (2) @(posedge MCLK_I);
        wait_run(n);
        rd(4'h1, d);
        `CHK(d, 8'h02)
        rd(4'h0, d);
        `CHK(d, 8'h82)
        $display("watchdog and resistor-cap test done");
        @(posedge MCLK_I);
        RST_B_I <= 1'h0;
        MASTER_CLEAR_PIN_B_I <= 1'h0;
        repeat (10) @(posedge MCLK_I);
        RST_B_I <= 1'h1;
        repeat (80) @(posedge MCLK_I);
        #1 `CHK(CORE_RST_B_O, 1'h0)
        @(posedge MCLK_I);
        MASTER_CLEAR_PIN_B_I <= 1'h1;
        wait_run(n);
        `CHK(n <= 3, 1'h1)
        $display("master clear test done");
        @(posedge MCLK_I);
        WAKE_INT_I <= 1'h1;
        @(posedge MCLK_I);
        WAKE_INT_I <= 1'h0;
        n = 0;
        repeat (20) begin
            @(posedge MCLK_I);
            #1 if (WAKE_HOLD_O === 1'h1) n++;
        end
        `CHK(n, OS)
        rd(4'h1, d);
        `CHK(d, 8'h01)
        $display("wake test done");
        tally_and_finish();
    end
endmodule

// ==== inc/bprs_pkg.sv ====
// Constants for the brown-out / parity reset sequencer.
// Assumes a single 10 MHz core clock and one synchronous reset.
package bprs_pkg;
    // Clock
    localparam int CLK_HZ = 10_000_000;
    // Timing, in their own units
    localparam int PWRUP_DELAY_MS = 72;
    localparam int OSC_STARTUP_CYC = 1024;
    localparam int BOR_QUAL_NS = 100;
    // Derived cycle counts (longest times round down, least round up)
    localparam int PWRUP_DELAY_CYC = PWRUP_DELAY_MS * (CLK_HZ / 1000);
    localparam int BOR_QUAL_CYC =
        (BOR_QUAL_NS * (CLK_HZ / 1_000_000) + 999) / 1000 < 1 ? 1 :
        (BOR_QUAL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // Register map
    localparam logic [3:0] ADDR_PWR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_CORE_STATUS = 4'h1;
    localparam logic [3:0] ADDR_CFG = 4'h2;
    // Power status bit positions
    localparam int BIT_BOR = 0;
    localparam int BIT_POR = 1;
    localparam int BIT_PER = 2;
    localparam int BIT_MPE = 7;
    // Core status bit positions
    localparam int BIT_WDT = 0;
    localparam int BIT_SLP = 1;
    // Configuration bit positions
    localparam int CFG_BOD = 0;
    localparam int CFG_POWERUP_DELAY_TIMER = 1;
    localparam int CFG_MPE = 2;
    localparam int CFG_OSC_LO = 3;
    // Oscillator mode codes
    localparam logic [1:0] OSC_LP = 2'h0;
    localparam logic [1:0] OSC_XT = 2'h1;
    localparam logic [1:0] OSC_HS = 2'h2;
    localparam logic [1:0] OSC_RC = 2'h3;
    // Configuration register reset value: detect, parity on, crystal
    localparam logic [7:0] CFG_RESET = 8'h0D;
endpackage

// ==== rtl/bprs_sequencer.sv ====
// Reset sequencer: brown-out qualification, power-up delay, oscillator
// start-up count, reset-cause flags and program-word parity checking.
// Assumes inputs synchronous to MCLK_I; RST_B_I stands for power-on.
//
// Implementation choices: the strobed register port and the address map.
module bprs_sequencer #(
    parameter int WORD_W = 14,
    parameter int PWRUP_CYC = bprs_pkg::PWRUP_DELAY_CYC,
    parameter int OST_CYC = bprs_pkg::OSC_STARTUP_CYC,
    parameter bit HAS_BOR = 1'b1
) (
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic RST_B_I,
    // Supply and pins
    input wire logic SUPPLY_LOW_I,
    input wire logic MASTER_CLEAR_PIN_B_I,
    // Core events
    input wire logic WDT_TIMEOUT_I,
    input wire logic SLEEP_I,
    input wire logic WAKE_WDT_I,
    input wire logic WAKE_INT_I,
    // Program fetch
    input wire logic FETCH_I,
    input wire logic [WORD_W-1:0] FETCH_WORD_I,
    input wire logic FETCH_PAR_EVEN_I,
    input wire logic FETCH_PAR_ODD_I,
    // Register port
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    // Reset and status outputs
    output logic CORE_RST_B_O,
    output logic WAKE_HOLD_O,
    output logic PARITY_ERR_O
);
    typedef enum logic [2:0] {
        BPRS_HOLD, BPRS_BROWN, BPRS_POWERUP_DELAY_TIMER, BPRS_OST, BPRS_RUN
    } bprs_state_e;

    bprs_state_e state;
    logic [31:0] cnt;
    logic [31:0] qual_cnt;
    logic [7:0] cfg;
    logic bor_flag, por_flag, per_flag, wdt_flag, slp_flag;
    logic brown_rst, par_err, master_clear_pin_asleep;
    logic wake_cnt_run;
    logic [31:0] wake_cnt;
    logic crystal, powerup_delay_timer_on, bod_on, mpe_on;
    logic [WORD_W-1:0] even_mask;

    assign bod_on = HAS_BOR && cfg[bprs_pkg::CFG_BOD];
    // Delay enable is active low on brown-out variants
    assign powerup_delay_timer_on = HAS_BOR ? !cfg[bprs_pkg::CFG_POWERUP_DELAY_TIMER]
                             : cfg[bprs_pkg::CFG_POWERUP_DELAY_TIMER];
    assign mpe_on = cfg[bprs_pkg::CFG_MPE];
    assign crystal =
        cfg[bprs_pkg::CFG_OSC_LO +: 2] != bprs_pkg::OSC_RC;

    // Even-position mask for the parity check
    genvar gi;
    generate
        for (gi = 0; gi < WORD_W; gi++) begin : g_mask
            assign even_mask[gi] = (gi % 2) == 0;
        end
    endgenerate

    // Even bits XOR even parity; odd bits XOR inverted odd parity
    assign par_err = mpe_on && FETCH_I && state == BPRS_RUN &&
        ((^(FETCH_WORD_I & even_mask) ^ FETCH_PAR_EVEN_I) |
         (^(FETCH_WORD_I & ~even_mask) ^ ~FETCH_PAR_ODD_I));

    // Supply-low must persist for the qualification time
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I || !SUPPLY_LOW_I || !bod_on) begin
            qual_cnt <= '0;
        end else if (qual_cnt < bprs_pkg::BOR_QUAL_CYC) begin
            qual_cnt <= qual_cnt + 32'h1;
        end
    end
    assign brown_rst = bod_on && SUPPLY_LOW_I &&
        qual_cnt >= bprs_pkg::BOR_QUAL_CYC - 1;

    // Reset sequence
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            state <= BPRS_HOLD;
            cnt <= '0;
        end else begin
            case (state)
                BPRS_HOLD: begin
                    cnt <= '0;
                    if (powerup_delay_timer_on) begin
                        state <= BPRS_POWERUP_DELAY_TIMER;
                    end else if (crystal) begin
                        state <= BPRS_OST;
                    end else begin
                        state <= BPRS_RUN;
                    end
                end
                BPRS_BROWN: begin
                    cnt <= '0;
                    if (!SUPPLY_LOW_I) begin
                        state <= BPRS_POWERUP_DELAY_TIMER;
                    end
                end
                BPRS_POWERUP_DELAY_TIMER: begin
                    if (brown_rst) begin
                        state <= BPRS_BROWN;
                        cnt <= '0;
                    end else if (cnt >= PWRUP_CYC - 1) begin
                        cnt <= '0;
                        state <= crystal ? BPRS_OST : BPRS_RUN;
                    end else begin
                        cnt <= cnt + 32'h1;
                    end
                end
                BPRS_OST: begin
                    if (brown_rst) begin
                        state <= BPRS_BROWN;
                        cnt <= '0;
                    end else if (cnt >= OST_CYC - 1) begin
                        cnt <= '0;
                        state <= BPRS_RUN;
                    end else begin
                        cnt <= cnt + 32'h1;
                    end
                end
                BPRS_RUN: begin
                    cnt <= '0;
                    if (brown_rst) begin
                        state <= BPRS_BROWN;
                    end else if (par_err) begin
                        state <= powerup_delay_timer_on ? BPRS_POWERUP_DELAY_TIMER
                               : (crystal ? BPRS_OST : BPRS_RUN);
                    end
                end
                default: begin
                    state <= BPRS_HOLD;
                    cnt <= '0;
                end
            endcase
        end
    end

    // Wake from sleep: crystal modes wait the oscillator count
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            wake_cnt_run <= 1'b0;
            wake_cnt <= '0;
        end else if (!wake_cnt_run && (WAKE_WDT_I || WAKE_INT_I)
                     && crystal) begin
            wake_cnt_run <= 1'b1;
            wake_cnt <= '0;
        end else if (wake_cnt_run) begin
            if (wake_cnt >= OST_CYC - 1) begin
                wake_cnt_run <= 1'b0;
            end
            wake_cnt <= wake_cnt + 32'h1;
        end
    end

    // Master clear asserted while the core sleeps
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            master_clear_pin_asleep <= 1'b0;
        end else if (MASTER_CLEAR_PIN_B_I) begin
            master_clear_pin_asleep <= 1'b0;
        end else if (SLEEP_I) begin
            master_clear_pin_asleep <= 1'b1;
        end
    end

    // Configuration register
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            cfg <= bprs_pkg::CFG_RESET;
        end else if (WR_I && ADDR_I == bprs_pkg::ADDR_CFG) begin
            cfg <= WDATA_I;
        end
    end

    // Power status flags: hardware clear wins over software set for BOR and PER; POR has no hardware clear
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            por_flag <= 1'b0;
            bor_flag <= 1'b0;
            per_flag <= 1'b1;
        end else begin
            if (brown_rst) begin
                bor_flag <= 1'b0;
            end else if (WR_I && ADDR_I == bprs_pkg::ADDR_PWR_STATUS) begin
                bor_flag <= WDATA_I[bprs_pkg::BIT_BOR];
            end
            if (WR_I && ADDR_I == bprs_pkg::ADDR_PWR_STATUS) begin
                por_flag <= WDATA_I[bprs_pkg::BIT_POR];
            end
            if (par_err) begin
                per_flag <= 1'b0;
            end else if (WR_I && ADDR_I == bprs_pkg::ADDR_PWR_STATUS) begin
                per_flag <= WDATA_I[bprs_pkg::BIT_PER];
            end
        end
    end

    // Watchdog-expired and sleep-entered flags
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            wdt_flag <= 1'b1;
            slp_flag <= 1'b1;
        end else if (WDT_TIMEOUT_I && SLEEP_I) begin
            wdt_flag <= 1'b0;
            slp_flag <= 1'b0;
        end else if (WDT_TIMEOUT_I) begin
            wdt_flag <= 1'b0;
            slp_flag <= 1'b1;
        end else if (WAKE_INT_I || (!MASTER_CLEAR_PIN_B_I && SLEEP_I)) begin
            wdt_flag <= 1'b1;
            slp_flag <= 1'b0;
        end
    end

    // Outputs
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            CORE_RST_B_O <= 1'b0;
        end else begin
            CORE_RST_B_O <= state == BPRS_RUN && !brown_rst && !par_err
                && MASTER_CLEAR_PIN_B_I;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            WAKE_HOLD_O <= 1'b0;
            PARITY_ERR_O <= 1'b0;
        end else begin
            // One cycle behind the counter, so the hold spans OST_CYC
            WAKE_HOLD_O <= wake_cnt_run;
            PARITY_ERR_O <= par_err;
        end
    end

    // Read port
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            RDATA_O <= 8'h00;
        end else if (RD_I) begin
            case (ADDR_I)
                bprs_pkg::ADDR_PWR_STATUS:
                    RDATA_O <= {mpe_on, 4'h0, per_flag, por_flag,
                                bor_flag};
                bprs_pkg::ADDR_CORE_STATUS:
                    RDATA_O <= {6'h00, slp_flag, wdt_flag};
                bprs_pkg::ADDR_CFG:
                    RDATA_O <= cfg;
                default:
                    RDATA_O <= 8'h00;
            endcase
        end else begin
            RDATA_O <= 8'h00;
        end
    end
endmodule
